// *** rtl/comparator2_control.sv ***
// Purpose: Control register, routing and output path of comparator two.
// Assumes: APB slave, single clock, synchronous active-high reset.
// Notes:   Raw comparator output arrives as a level; pin path is unlatched.
//          Clock enable low freezes register, status, event and read data.
//          Unmapped offsets answer with an error and read back as zero.
//          Analog pin selection stays with software; nothing checks it here.
// How it works
// - Enable bit seven turns comparator on
// - Low two bits pick inverting pin
// - Bit two picks internal or external reference
// - Bit six reads latched result, read only
// - Invert bit flips status and pin
// - Result one when inverting input lower
// - Status latched every instruction cycle
// - Pin output is unlatched result
// - Change event independent of pin enable
// - Pin drives only when all enables allow
`default_nettype none
module comparator2_control (
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  input  wire logic                   instr_cycle_end,
  input  wire logic                   raw_compare,
  input  wire logic                   port_c_direction_bit4,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output cmp_two_pkg::route_s         route,
  output logic                        pin_out,
  output logic                        pin_oe,
  output logic                        result_change
);
  import cmp_two_pkg::*;

  ctrl_s       ctrl_q;
  logic        result_q;
  logic        polar;
  logic        hit;
  logic        wr_fire;
  logic [7:0]  reg_view;

  // Polarity applied to the raw compare (raw high means inverting below)
  function automatic logic apply_polarity(input logic raw, input logic inv);
    apply_polarity = raw ^ inv;
  endfunction : apply_polarity

  // One-hot pin pick for a channel code, shared by routing checks
  function automatic logic [3:0] channel_onehot(input logic [1:0] code);
    channel_onehot = 4'h1 << code;
  endfunction : channel_onehot

  assign polar   = ctrl_q.enable & apply_polarity(raw_compare, ctrl_q.invert);
  assign hit     = (paddr == CTRL_OFFSET);
  assign wr_fire = psel & penable & pwrite & hit & pstrb[0] & clk_en;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Control register write, reserved bit ignored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= '0;
    end else if (wr_fire) begin
      ctrl_q.enable     <= pwdata[POS_ENABLE];
      ctrl_q.pin_enable <= pwdata[POS_PIN_EN];
      ctrl_q.invert     <= pwdata[POS_INVERT];
      ctrl_q.ref_select <= pwdata[POS_REF_SEL];
      ctrl_q.channel    <= pwdata[1:0];
    end
  end

  // Status latch, updated only at instruction cycle end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      result_q <= 1'b0;
    end else if (clk_en && instr_cycle_end) begin
      result_q <= polar;
    end
  end

  // Change event from the latched status, pin enable plays no part
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      result_change <= 1'b0;
    end else if (clk_en) begin
      result_change <= instr_cycle_end & (polar != result_q);
    end
  end

  // Read view of the control register
  always_comb begin
    reg_view               = CTRL_RESET & CTRL_WR_MASK;
    reg_view[POS_ENABLE]   = ctrl_q.enable;
    reg_view[POS_RESULT]   = result_q;
    reg_view[POS_PIN_EN]   = ctrl_q.pin_enable;
    reg_view[POS_INVERT]   = ctrl_q.invert;
    reg_view[POS_REF_SEL]  = ctrl_q.ref_select;
    reg_view[1:0]          = ctrl_q.channel;
  end

  // Read data register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= RDATA_ZERO;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= hit ? {24'h000000, reg_view} : RDATA_ZERO;
    end
  end

  // Analog routing; software must set analog select bits first
  always_comb begin
    route.active           = ctrl_q.enable;
    route.use_internal_ref = ctrl_q.ref_select;
    route.inv_pin_onehot   = 4'h0;
    case (ctrl_q.channel)
      CH_AN1:  route.inv_pin_onehot = 4'h1;
      CH_AN5:  route.inv_pin_onehot = 4'h2;
      CH_AN6:  route.inv_pin_onehot = 4'h4;
      CH_AN7:  route.inv_pin_onehot = 4'h8;
      default: route.inv_pin_onehot = 4'h0;
    endcase
  end

  // Pin path is unlatched
  assign pin_out = polar;
  assign pin_oe  = ctrl_q.pin_enable & ctrl_q.enable & ~port_c_direction_bit4;

  // Status takes the polar result at each cycle end
  a_status_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && instr_cycle_end |=> result_q == $past(polar))
    else $error("status not latched");

  // Status holds between cycle ends
  a_status_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(clk_en && instr_cycle_end) |=> $stable(result_q))
    else $error("status changed off cycle end");

  // Pin drive needs all three conditions
  a_pin_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pin_oe == (ctrl_q.pin_enable && ctrl_q.enable && !port_c_direction_bit4))
    else $error("pin enable wrong");

  // Pin level follows polarity while enabled
  a_pin_polar: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl_q.enable |-> pin_out == (raw_compare ^ ctrl_q.invert))
    else $error("pin polarity wrong");

  // Enable bit lands on a write
  a_enable_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_fire |=> route.active == $past(pwdata[POS_ENABLE]))
    else $error("enable not written");

  // Reference route mirrors its bit
  a_ref_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    route.use_internal_ref == ctrl_q.ref_select)
    else $error("reference route wrong");

  // Exactly one inverting pin per channel code
  a_channel_onehot: assert property (@(posedge clk_sys) disable iff (sys_rst)
    route.inv_pin_onehot == channel_onehot(ctrl_q.channel))
    else $error("channel decode wrong");

  // Unimplemented bit reads zero
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_view[3] == 1'b0)
    else $error("reserved bit nonzero");

  // Reset clears control and status
  a_reset_clear: assert property (@(posedge clk_sys)
    sys_rst |=> ctrl_q == '0 && result_q == 1'b0)
    else $error("reset did not clear");

  // A latched change raises the event
  a_change_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && instr_cycle_end && polar != result_q |=> result_change)
    else $error("change event missed");

  // Disabled comparator latches zero
  a_disabled_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctrl_q.enable && clk_en && instr_cycle_end |=> !result_q)
    else $error("disabled result not zero");

  // Latched status is raw result through polarity
  a_status_polarity: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && instr_cycle_end && ctrl_q.enable |=>
      result_q == ($past(raw_compare) ^ $past(ctrl_q.invert)))
    else $error("status polarity wrong");

  // Writes never reach the status bit
  a_result_readonly: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_fire && !instr_cycle_end |=> $stable(result_q))
    else $error("status bit written");

  // Read data carries the register view
  a_read_view: assert property (@(posedge clk_sys) disable iff (sys_rst)
    psel && !penable && !pwrite && hit && clk_en |=> prdata[7:0] == $past(reg_view))
    else $error("read data wrong");

  // Upper read lanes stay zero
  a_read_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
    prdata[31:8] == 24'h000000)
    else $error("upper read lanes nonzero");

  // Invert bit lands on a write
  a_invert_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_fire |=> ctrl_q.invert == $past(pwdata[POS_INVERT]))
    else $error("invert not written");

  // Reference bit lands on a write
  a_ref_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_fire |=> route.use_internal_ref == $past(pwdata[POS_REF_SEL]))
    else $error("reference not written");

  // Channel code lands on a write and picks its pin
  a_channel_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_fire |=> route.inv_pin_onehot == channel_onehot($past(pwdata[1:0])))
    else $error("channel not written");

  // Comparator activity mirrors the enable bit
  a_active_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    route.active == ctrl_q.enable)
    else $error("active route wrong");

  // Pin path has no storage stage
  a_pin_unlatched: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pin_out == (ctrl_q.enable && (raw_compare != ctrl_q.invert)))
    else $error("pin path not direct");

  // Disabled comparator neither drives nor shows a level
  a_pin_off_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctrl_q.enable |-> !pin_oe && !pin_out)
    else $error("pin active while disabled");

  // Input direction keeps the pin undriven
  a_oe_needs_dir: assert property (@(posedge clk_sys) disable iff (sys_rst)
    port_c_direction_bit4 |-> !pin_oe)
    else $error("pin driven as input");

  // Disabled comparator routes nothing active
  a_disabled_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctrl_q.enable |-> !route.active)
    else $error("route active while disabled");

  // Unmapped writes leave the register alone
  a_unmapped_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    psel && penable && pwrite && !hit |=> $stable(ctrl_q))
    else $error("unmapped write landed");

  // Writes without lane zero are refused
  a_lane_refused: assert property (@(posedge clk_sys) disable iff (sys_rst)
    psel && penable && pwrite && hit && !pstrb[0] |=> $stable(ctrl_q))
    else $error("write without lane landed");

  // Error answer only for unmapped access
  a_slverr_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pslverr == (psel && penable && !hit))
    else $error("error answer wrong");

  // No event without a cycle end
  a_change_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && !instr_cycle_end |=> !result_change)
    else $error("spurious change event");

  // Clock enable low freezes the register
  a_freeze_ctrl: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(ctrl_q))
    else $error("register moved while frozen");

  // Clock enable low freezes the status
  a_freeze_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(result_q))
    else $error("status moved while frozen");

  // Clock enable low freezes the event
  a_freeze_change: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(result_change))
    else $error("event moved while frozen");

  // Clock enable low freezes read data
  a_freeze_rdata: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(prdata))
    else $error("read data moved while frozen");

  // Main scenarios
  c_write_read: cover property (@(posedge clk_sys) wr_fire ##[1:8] (psel && !pwrite));
  c_pin_drive:  cover property (@(posedge clk_sys) pin_oe && pin_out);
  c_change:     cover property (@(posedge clk_sys) result_change);
  c_unmapped:   cover property (@(posedge clk_sys) pslverr);
  c_freeze:     cover property (@(posedge clk_sys) !clk_en ##1 clk_en);
endmodule : comparator2_control
`default_nettype wire

// *** rtl/cmp_two_pkg.sv ***
// Purpose: Shared constants and carriers for the comparator two control block.
// Assumes: 8-bit control register reached as one aligned APB word.
// Notes:   Field positions and reset values live here, except channel bits 1:0, which the RTL writes inline.
`default_nettype none
package cmp_two_pkg;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam int          POS_ENABLE    = 7;
  localparam int          POS_RESULT    = 6;
  localparam int          POS_PIN_EN    = 5;
  localparam int          POS_INVERT    = 4;
  localparam int          POS_REF_SEL   = 2;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK  = 8'hB7;
  localparam logic [1:0]  CH_AN1        = 2'h0;
  localparam logic [1:0]  CH_AN5        = 2'h1;
  localparam logic [1:0]  CH_AN6        = 2'h2;
  localparam logic [1:0]  CH_AN7        = 2'h3;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // Software controlled fields of the control register
  typedef struct packed {
    logic       enable;
    logic       pin_enable;
    logic       invert;
    logic       ref_select;
    logic [1:0] channel;
  } ctrl_s;

  // Analog routing selections handed to the comparator
  typedef struct packed {
    logic       active;
    logic [3:0] inv_pin_onehot;
    logic       use_internal_ref;
  } route_s;
endpackage : cmp_two_pkg
`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the comparator two control block.
// Assumes: APB slave answers with pready; status latches on instr_cycle_end.
// Notes:   Bench drives every port itself; no partner model.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_two_pkg::*;
  logic        clk_sys = 0, sys_rst = 1, clk_en = 1, instr_cycle_end = 0, raw_compare = 0;
  logic        port_c_direction_bit4 = 1, psel = 0, penable = 0, pwrite = 0, err, seen;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, pin_out, pin_oe, result_change;
  route_s      route;
  int          error_cnt = 0, checks = 0, cyc = 0;
  comparator2_control dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .instr_cycle_end(instr_cycle_end), .raw_compare(raw_compare),
    .port_c_direction_bit4(port_c_direction_bit4), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .route(route), .pin_out(pin_out),
    .pin_oe(pin_oe), .result_change(result_change));
  // Clock and hang guard
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk_sys);
  endtask : apb
  // Latch pulse, then watch for the change event
  task automatic tick;
    instr_cycle_end <= 1;
    @(posedge clk_sys) instr_cycle_end <= 0;
    seen = 0;
    repeat (3) @(posedge clk_sys) seen |= (result_change === 1'b1);
  endtask : tick
  task automatic t_fields;
    apb(0, CTRL_OFFSET, 0); chk(rd, 0, "reset value");
    chk({route.active, pin_oe}, 0, "reset outputs");
    apb(1, CTRL_OFFSET, 32'hFF); apb(0, CTRL_OFFSET, 0);
    chk(rd, 32'hB7, "masked bits");
    // Channel pins taken as already analog-selected by software
    for (int c = 0; c < 4; c++) begin
      apb(1, CTRL_OFFSET, 32'h80 | c | ((c & 1) << 2));
      chk(route.inv_pin_onehot, 4'h1 << c, "channel");
      chk(route.use_internal_ref, c & 1, "reference");
      chk(route.active, 1, "active");
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_pin;
    port_c_direction_bit4 <= 0;
    for (int k = 0; k < 4; k++) begin
      apb(1, CTRL_OFFSET, 32'hA0 | ((k & 2) << 3));
      raw_compare <= k[0];
      @(posedge clk_sys);
      chk(pin_out, k[0] ^ k[1], "pin level");
      chk(pin_oe, 1, "pin drive");
    end
    port_c_direction_bit4 <= 1;
    @(posedge clk_sys); chk(pin_oe, 0, "direction input");
    port_c_direction_bit4 <= 0;
    apb(1, CTRL_OFFSET, 32'h20); chk({pin_oe, pin_out}, 0, "disabled pin");
    $display("test pin done");
  endtask : t_pin
  task automatic t_latch;
    raw_compare <= 1;
    apb(1, CTRL_OFFSET, 32'h80); apb(0, CTRL_OFFSET, 0);
    chk(rd[6], 0, "not yet latched");
    tick(); chk(seen, 1, "change event");
    apb(0, CTRL_OFFSET, 0); chk(rd, 32'hC0, "latched one");
    apb(1, CTRL_OFFSET, 32'h90); tick();
    apb(0, CTRL_OFFSET, 0); chk(rd, 32'h90, "inverted status");
    $display("test latch done");
  endtask : t_latch
  task automatic t_unmapped;
    apb(1, 12'h004, 32'hFF); chk(err, 1, "unmapped write error");
    apb(0, 12'h004, 0); chk(err, 1, "unmapped read error");
    chk(rd, 0, "unmapped read data");
    apb(0, CTRL_OFFSET, 0); chk(err, 0, "mapped no error");
    chk(rd, 32'h90, "untouched");
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic t_freeze;
    clk_en <= 0;
    apb(1, CTRL_OFFSET, 0);
    clk_en <= 1;
    apb(0, CTRL_OFFSET, 0); chk(rd, 32'h90, "frozen write ignored");
    $display("test freeze done");
  endtask : t_freeze
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    t_fields(); t_pin(); t_latch(); t_unmapped(); t_freeze();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
